// file: flash_stream_cfg.svh
// constants for the configuration flash stream reader
// How it works
// RULE1: in streaming, address counter advances by one each read clock, new word shown.
// RULE2: a 16-bit array word is driven onto data pins each clock cycle.
// RULE3: the target captures the shown word on its next configuration clock edge.
// RULE4: one external clock drives both flash read clock and target clock.
// RULE5: starting address zero is latched from all-low 23-bit address inputs; the code loads START_ADDR on the init rise and ignores addr_in.
// RULE6: start address loads on rising edge of the shared init handshake line.
// RULE7: address latch enable stays high through configuration, no address disturbs counter.
// RULE8: chip enable stays low through configuration so the flash stays selected.
// RULE9: write enable high keeps the write function disabled.
// RULE10: output enable low enables the data outputs.
// RULE11: with chip enable high, address, data, write and output pins are ignored.
// RULE12: the target infers 16-bit width from low byte, ignores upper lines.
// RULE13: programming core drives 26-bit address; only low 23 bits reach flash.
// RULE14: in indirect programming the 16-bit data bus is bidirectional.
// RULE15: programming core toggles write and output strobes as accesses need.
// RULE16: read clock unused in indirect programming; accesses qualified by strobes only.
`ifndef FLASH_STREAM_CFG_SVH
`define FLASH_STREAM_CFG_SVH
`define ADDR_W      23
`define DATA_W      16
`define ARRAY_WORDS 256
`define START_ADDR  23'h000000
`endif

// file: flash_stream_pkg.sv
// types for the configuration flash stream reader
`include "flash_stream_cfg.svh"
package flash_stream_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] word_t;
  typedef enum logic [1:0] {
    st_idle   = 2'h0,
    st_stream = 2'h1,
    st_async  = 2'h3
  } mode_t;
endpackage

// file: flash_x16_config_stream_read.sv
// configuration flash: synchronous stream and asynchronous access
`timescale 1ns/1ps
`include "flash_stream_cfg.svh"
module flash_x16_config_stream_read
  import flash_stream_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  srst,
  input  wire logic  target_config_clock,
  input  wire logic  init_ready,
  input  wire logic  target_flash_select_n,
  input  wire logic  addr_latch_n,
  input  wire logic  target_flash_write_strobe_n,
  input  wire logic  target_flash_output_strobe_n,
  input  wire addr_t addr_in,
  input  wire word_t data_in,
  output logic       data_out,
  output word_t      data_bus_out,
  output logic       data_oe
);
  // 3-stage synchronisers for every pin input
  logic [2:0] s_clk, s_init, s_ce, s_al, s_we, s_oe;
  addr_t      a1, a2, a3;
  word_t      d1, d2, d3;
  always_ff @(posedge clk_sys) begin
    s_clk  <= {s_clk[1:0],  target_config_clock};
    s_init <= {s_init[1:0], init_ready};
    s_ce   <= {s_ce[1:0],   target_flash_select_n};
    s_al   <= {s_al[1:0],   addr_latch_n};
    s_we   <= {s_we[1:0],   target_flash_write_strobe_n};
    s_oe   <= {s_oe[1:0],   target_flash_output_strobe_n};
    a1 <= addr_in; a2 <= a1; a3 <= a2;
    d1 <= data_in; d2 <= d1; d3 <= d2;
  end

  function automatic logic agreed(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  localparam int SLOT_W = $clog2(`ARRAY_WORDS);

  // array slot of an address, depth is a power of two
  function automatic logic [SLOT_W-1:0] slot(input addr_t a);
    return a[SLOT_W-1:0];
  endfunction

  // filtered levels
  logic clk_f, init_f, ce_n_f, al_n_f, we_n_f, oe_n_f;
  logic next_clk_f, next_init_f, next_ce_n_f, next_al_n_f, next_we_n_f, next_oe_n_f;
  always_comb begin
    next_clk_f  = agreed(s_clk,  clk_f);
    next_init_f = agreed(s_init, init_f);
    next_ce_n_f = agreed(s_ce,   ce_n_f);
    next_al_n_f = agreed(s_al,   al_n_f);
    next_we_n_f = agreed(s_we,   we_n_f);
    next_oe_n_f = agreed(s_oe,   oe_n_f);
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_f  <= 1'b0;
      init_f <= 1'b0;
      ce_n_f <= 1'b1;
      al_n_f <= 1'b1;
      we_n_f <= 1'b1;
      oe_n_f <= 1'b1;
    end else begin
      clk_f  <= next_clk_f;
      init_f <= next_init_f;
      ce_n_f <= next_ce_n_f;
      al_n_f <= next_al_n_f;
      we_n_f <= next_we_n_f;
      oe_n_f <= next_oe_n_f;
    end
  end

  word_t array_mem [`ARRAY_WORDS];
  mode_t mode, next_mode;
  addr_t counter, next_counter;
  word_t out_word, next_out_word;
  logic  out_en, next_out_en, rise_clk, rise_init;
  logic  wr_hit;
  assign rise_clk  = next_clk_f & ~clk_f;
  assign rise_init = next_init_f & ~init_f;
  assign wr_hit    = (mode == st_async) & ~ce_n_f & ~we_n_f & next_we_n_f; // [RULE15] [RULE14]

  always_comb begin
    next_mode     = mode;
    next_counter  = counter;
    next_out_word = out_word;
    next_out_en   = 1'b0;
    case (mode)
      st_idle: begin
        if (rise_init) begin
          next_mode    = st_stream;
          next_counter = `START_ADDR; // [RULE5] [RULE6]
          next_out_word = array_mem[slot(`START_ADDR)];
        end
      end
      st_stream: begin
        if (~al_n_f) begin
          next_mode = st_async; // latch enable low leaves streaming
        end else if (rise_clk & ~ce_n_f) begin
          next_counter  = addr_t'(counter + 1'b1); // [RULE1] [RULE7]
          next_out_word = array_mem[slot(next_counter)]; // [RULE2]
        end
        next_out_en = ~ce_n_f & ~oe_n_f & we_n_f; // [RULE10] [RULE8] [RULE11]
      end
      st_async: begin
        if (~ce_n_f & ~al_n_f) begin
          next_counter = a3; // [RULE13] [RULE16]
        end
        next_out_word = array_mem[slot(next_counter)];
        next_out_en   = ~ce_n_f & ~oe_n_f & we_n_f; // [RULE14] [RULE11]
      end
      default: next_mode = st_idle;
    endcase
    if (~init_f & ~next_init_f) begin
      next_mode = st_idle;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode     <= st_idle;
      counter  <= `START_ADDR;
      out_word <= '0;
      out_en   <= 1'b0;
    end else begin
      mode     <= next_mode;
      counter  <= next_counter;
      out_word <= next_out_word;
      out_en   <= next_out_en;
    end
  end

  // write port, only with select low and write strobe low [RULE9]
  always_ff @(posedge clk_sys) begin
    if (wr_hit) begin
      array_mem[slot(counter)] <= d3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_bus_out <= '0;
      data_oe      <= 1'b0;
      data_out     <= 1'b0;
    end else begin
      data_bus_out <= out_word;
      data_oe      <= out_en;
      data_out     <= out_en & (mode == st_stream);
    end
  end

  property p_we_blocks_out;
    @(posedge clk_sys) disable iff (srst) we_n_f == 1'b0 |=> !out_en;
  endproperty
  a_we_blocks_out: assert property (p_we_blocks_out) else $error("output on during write"); // [RULE9]

  property p_ce_blocks_out;
    @(posedge clk_sys) disable iff (srst) ce_n_f |=> !out_en ##1 !data_oe;
  endproperty
  a_ce_blocks_out: assert property (p_ce_blocks_out) else $error("drive while deselected"); // [RULE11]

  property p_start_zero;
    @(posedge clk_sys) disable iff (srst) (mode == st_idle && rise_init) |=> counter == `START_ADDR;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start address not zero"); // [RULE5]

  property p_step_one;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_stream && al_n_f && rise_clk && !ce_n_f) |=> counter == $past(counter) + 1'b1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("counter did not step"); // [RULE1]

  property p_hold;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_stream && !rise_clk && al_n_f && init_f) |=> $stable(counter);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without clock"); // [RULE7]

  property p_oe_en;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_stream && !ce_n_f && !oe_n_f && we_n_f && next_mode == st_stream) |=> out_en ##1 data_oe;
  endproperty
  a_oe_en: assert property (p_oe_en) else $error("outputs not enabled"); // [RULE10]

  property p_word_out;
    @(posedge clk_sys) disable iff (srst)
      out_en |-> out_word == array_mem[slot(counter)] ##1 data_bus_out == $past(out_word);
  endproperty
  a_word_out: assert property (p_word_out) else $error("wrong word driven"); // [RULE2]

  property p_async_addr;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_async && !ce_n_f && !al_n_f && next_mode == st_async) |=> counter == $past(a3);
  endproperty
  a_async_addr: assert property (p_async_addr) else $error("async address not taken"); // [RULE16]

  // mode changes and idle output around the init line and the latch enable
  property p_init_start;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_idle && rise_init) |=> mode == st_stream;
  endproperty
  a_init_start: assert property (p_init_start) else $error("init rise did not start stream"); // [RULE6]

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (srst)
      mode == st_idle |=> !out_en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output on while idle"); // [RULE6]

  property p_init_drop;
    @(posedge clk_sys) disable iff (srst)
      (!init_f && !next_init_f && mode != st_idle) |=> mode == st_idle;
  endproperty
  a_init_drop: assert property (p_init_drop) else $error("init low did not return to idle"); // [RULE6]

  property p_latch_exit;
    @(posedge clk_sys) disable iff (srst)
      (mode == st_stream && !al_n_f && init_f) |=> mode == st_async;
  endproperty
  a_latch_exit: assert property (p_latch_exit) else $error("latch low did not leave stream"); // [RULE7]
endmodule

// file: config_target_model.sv
// model of the configuring target and its programming core
`timescale 1ns/1ps
module config_target_model
  import flash_stream_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire word_t rdata,
  output logic       cfg_clk,
  output logic       init_ready,
  output logic       select_n,
  output logic       latch_n,
  output logic       wr_n,
  output logic       oe_n,
  output addr_t      addr,
  output word_t      wdata,
  output logic       cap,
  output word_t      cap_word
);
  logic [25:0] core_addr;
  assign addr = core_addr[22:0];
  initial begin
    {cfg_clk, init_ready, select_n, latch_n, wr_n, oe_n} = 6'h07;
    core_addr = 26'h0;
    wdata = 16'h0;
    cap = 1'b0;
    cap_word = 16'h0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic grab(); // low word only, no wider lanes
    cap = 1'b1;
    cap_word = rdata;
    idle(1);
    cap = 1'b0;
  endtask
  // async access, read clock held still
  task automatic acc(input logic [25:0] a, input word_t d, input logic we, input logic sel_n);
    idle(1);
    init_ready = 1'b1;
    latch_n = 1'b0;
    select_n = sel_n;
    core_addr = a;
    wdata = d;
    idle(6);
    if (we) wr_n = 1'b0;
    else oe_n = 1'b0;
    idle(8);
    if (!we) grab();
    wr_n = 1'b1;
    oe_n = 1'b1;
    idle(6);
    wdata = ~wdata;
    select_n = 1'b1;
  endtask
  task automatic stream(input int n);
    idle(1);
    latch_n = 1'b1;
    select_n = 1'b0;
    oe_n = 1'b0;
    init_ready = 1'b0;
    idle(8);
    init_ready = 1'b1;
    idle(8);
    repeat (n) begin
      cfg_clk = 1'b1; // one source for both ends
      grab();
      idle(9);
      cfg_clk = 1'b0;
      idle(10);
    end
  endtask
endmodule

// file: tb_flash_x16_config_stream_read.sv
// testbench for the configuration flash stream reader
`timescale 1ns/1ps
`define check(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_flash_x16_config_stream_read
  import flash_stream_pkg::*;
;
  logic        clk_sys, srst, cfg_clk, init_ready, select_n, latch_n, wr_n, oe_n, cap;
  logic        data_out, data_oe;
  addr_t       addr;
  word_t       wdata, cap_word, data_bus_out, bus;
  word_t       mem [0:7];
  logic [17:0] expq [$];
  logic [17:0] note;
  int          err_count = 0;
  int          n_checks = 0;
  assign bus = data_oe ? data_bus_out : wdata;
  flash_x16_config_stream_read dut (.clk_sys(clk_sys), .srst(srst), .target_config_clock(cfg_clk),
    .init_ready(init_ready), .target_flash_select_n(select_n), .addr_latch_n(latch_n),
    .target_flash_write_strobe_n(wr_n), .target_flash_output_strobe_n(oe_n), .addr_in(addr),
    .data_in(bus), .data_out(data_out), .data_bus_out(data_bus_out), .data_oe(data_oe));
  config_target_model u_tgt (.clk_sys(clk_sys), .rdata(bus), .cfg_clk(cfg_clk), .init_ready(init_ready),
    .select_n(select_n), .latch_n(latch_n), .wr_n(wr_n), .oe_n(oe_n), .addr(addr), .wdata(wdata),
    .cap(cap), .cap_word(cap_word));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (cap === 1'b1) begin
      `check(expq.size() > 0, 1'b1)
      note = expq.pop_front();
      `check(data_oe, note[16])
      `check(data_out, note[17])
      if (note[16]) `check(cap_word, note[15:0])
    end
  end
  initial begin
    #100us;
    err_count++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    void'($urandom(9));
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    repeat (6) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      mem[i] = word_t'($urandom);
      u_tgt.acc(26'(i), mem[i], 1'b1, 1'b0);
    end
    mem[2] = word_t'($urandom);
    u_tgt.acc(26'h3800102, mem[2], 1'b1, 1'b0); // upper core bits unused
    u_tgt.acc(26'h1, ~mem[1], 1'b1, 1'b1); // deselected write ignored
    expq.push_back({2'b01, mem[4]});
    u_tgt.acc(26'h4, 16'h0000, 1'b0, 1'b0);
    expq.push_back({2'b00, 16'h0000});
    u_tgt.acc(26'h5, 16'h0000, 1'b0, 1'b1);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8 - 4 * r; i++) expq.push_back({2'b11, mem[i]});
      u_tgt.stream(8 - 4 * r); // write strobe high throughout
    end
    repeat (20) @(negedge clk_sys);
    `check(expq.size(), 0)
    wrap_up();
  end
endmodule
